// ---- logic/sac_cfg.svh ----
// offsets, field positions, reset values and timing counts of the converter control
// assumes a 25 MHz pclk and a 12-bit apb byte address
`ifndef SAC_CFG_SVH
`define SAC_CFG_SVH

// ****************************************
// register offsets
// ****************************************
`define SAC_OFS_INSEL      12'h000
`define SAC_OFS_CFG        12'h004
`define SAC_OFS_RESULT     12'h008
`define SAC_OFS_CTRL       12'h00C
`define SAC_OFS_IRQEN      12'h010

// ****************************************
// field positions
// ****************************************
`define SAC_CTRL_EN        7
`define SAC_CTRL_TM        6
`define SAC_CTRL_DONE      5
`define SAC_CTRL_BUSY      4
`define SAC_CFG_DIV_LSB    3
`define SAC_CFG_UNUSED     2
`define SAC_INSEL_NEG_LSB  4
`define SAC_INSEL_NEG_GND  7

// ****************************************
// reset values and codes
// ****************************************
`define SAC_INSEL_RST      8'h00
`define SAC_CFG_RST        8'hF8
`define SAC_CTRL_RST       8'h00
`define SAC_RESULT_RST     8'h00
`define SAC_SRC_SW         3'h0
`define SAC_SRC_T0         3'h1
`define SAC_SRC_T2         3'h2
`define SAC_SRC_T1         3'h3
`define SAC_DIFF_FLIP      8'h80
`define SAC_SAR_FIRST      8'h80

// ****************************************
// timing
// ****************************************
`define SAC_CLK_NS         40
`define SAC_MAX_KSPS       500
`define SAC_CONV_MIN_NS    (1000000 / `SAC_MAX_KSPS)
`define SAC_CONV_MIN_CYC   ((`SAC_CONV_MIN_NS + `SAC_CLK_NS - 1) / `SAC_CLK_NS)
`define SAC_TRACK_CLKS     3
`define SAC_CONV_CLKS      9
`define SAC_SAR_MIN_DIV    ((`SAC_CONV_MIN_CYC + `SAC_CONV_CLKS - 1) / `SAC_CONV_CLKS - 1)

`endif

// ---- logic/sac_pkg.sv ----
// types shared by the converter control and its bench
// assumes sac_cfg.svh for the numeric constants
package sac_pkg;

  typedef enum logic [2:0] {
    SAC_IDLE  = 3'h1,
    SAC_TRACK = 3'h2,
    SAC_CONV  = 3'h4
  } sac_state_t;

  typedef enum logic [1:0] {
    SAC_GAIN_HALF = 2'h0,
    SAC_GAIN_ONE  = 2'h1,
    SAC_GAIN_TWO  = 2'h2,
    SAC_GAIN_FOUR = 2'h3
  } sac_gain_t;

  // overflow pulses and mode from the on-chip timers, all on pclk
  typedef struct packed {
    logic t0_ovf;
    logic t1_ovf;
    logic t2_lo_ovf;
    logic t2_hi_ovf;
    logic t2_8bit;
  } sac_timer_t;

  // controls toward the analog front end and sar array
  typedef struct packed {
    logic       powered;
    logic       track;
    logic [3:0] pos_sel;
    logic [3:0] neg_sel;
    logic       single_ended;
    sac_gain_t  gain;
    logic [7:0] trial;
  } sac_analog_t;

endpackage : sac_pkg

// ---- logic/sac_top.sv ----
// apb-controlled sequencer of an 8-bit successive-approximation converter
// assumes timer pulses on pclk, an asynchronous strobe pin and comparator output
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ps
`include "sac_cfg.svh"

// Operation
// - converter runs only while enable bit set
// - eleven input selections, positive and negative
// - ground negative means single-ended, else differential
// - single-ended result is unsigned 8-bit code
// - differential result is two's complement code
// - gain selectable, resets to one half
// - gain field codes 0.5, 1, 2, 4
// - sar clock is pclk over divider plus one; a divider below 5 is clamped to 5
// - one of five start sources selected
// - start-mode field encodes the source
// - busy write 1 starts only in software mode
// - timer 2 low or high overflow by mode
// - busy reads 1 throughout a conversion
// - busy fall sets done flag and interrupt
// - result valid when done flag reads 1
// - done flag sticky until software clears
// - normal mode tracks continuously except converting
// - low-power internal start tracks three sar clocks
// - low-power strobe mode tracks while strobe low
// - no tracking in standby or sleep
module sac_top
  import sac_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  sac_timer_t       timers,
  input  wire logic        ext_start_strobe,
  input  wire logic        low_power_standby,
  input  wire logic        sar_cmp,
  output sac_analog_t      analog_ctrl,
  output logic             conv_irq
);

  // ****************************************
  // decode helpers
  // ****************************************
  function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] ofs);
    addr_hit = (a[11:2] == ofs[11:2]);
  endfunction : addr_hit

  function automatic logic [7:0] fmt_code(input logic [7:0] raw, input logic single);
    fmt_code = single ? raw : (raw ^ `SAC_DIFF_FLIP);
  endfunction : fmt_code

  // ****************************************
  // state
  // ****************************************
  logic [7:0]  input_pair_select_reg;
  logic [7:0]  converter_config_reg;
  logic [7:0]  conversion_result_reg;
  logic        converter_on_bit_reg;
  logic        track_mode_select_reg;
  logic        conv_done_flag_reg;
  logic [2:0]  start_source_select_reg;
  logic        irq_enable_reg;
  sac_state_t  state_reg;
  logic [3:0]  step_reg;
  logic [7:0]  sar_reg;
  logic [4:0]  div_cnt_reg;
  logic        sar_tick_reg;
  logic        strobe_s1_reg;
  logic        strobe_s2_reg;
  logic        strobe_s3_reg;
  logic        cmp_s1_reg;
  logic        cmp_s2_reg;

  logic        apb_access;
  logic        wr_commit;
  logic        ctrl_wr;
  logic        cfg_wr;
  logic        busy;
  logic        single_ended;
  logic        t2_ovf;
  logic        strobe_rise;
  logic        start_evt;
  logic        fire;
  logic        conv_finish;
  logic [4:0]  div_eff;
  logic [2:0]  bit_idx;
  logic [7:0]  rd_word;
  logic        rd_hit;

  // ****************************************
  // apb slave
  // ****************************************
  assign apb_access = psel & penable & ~pready;
  assign wr_commit  = psel & penable & pready & pwrite;
  assign ctrl_wr    = wr_commit & addr_hit(paddr, `SAC_OFS_CTRL);
  assign cfg_wr     = wr_commit & addr_hit(paddr, `SAC_OFS_CFG);
  assign busy       = (state_reg != SAC_IDLE);

  always_comb begin
    rd_word = 8'h00;
    rd_hit  = 1'b1;
    if (addr_hit(paddr, `SAC_OFS_INSEL)) begin
      rd_word = input_pair_select_reg;
    end else if (addr_hit(paddr, `SAC_OFS_CFG)) begin
      rd_word = converter_config_reg;
    end else if (addr_hit(paddr, `SAC_OFS_RESULT)) begin
      rd_word = conversion_result_reg;
    end else if (addr_hit(paddr, `SAC_OFS_CTRL)) begin
      rd_word = {converter_on_bit_reg, track_mode_select_reg, conv_done_flag_reg,
                 busy, 1'b0, start_source_select_reg};
    end else if (addr_hit(paddr, `SAC_OFS_IRQEN)) begin
      rd_word = {7'h00, irq_enable_reg};
    end else begin
      rd_hit  = 1'b0;
    end
  end

  // answer one cycle into the access phase, data captured with it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= apb_access;
      if (apb_access) begin
        pslverr <= ~rd_hit;
        prdata  <= (pwrite | ~rd_hit) ? 32'h00000000 : {24'h000000, rd_word};
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // ****************************************
  // software registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_pair_select_reg <= `SAC_INSEL_RST;
      converter_config_reg  <= `SAC_CFG_RST;
      irq_enable_reg        <= 1'b0;
    end else begin
      if (wr_commit && addr_hit(paddr, `SAC_OFS_INSEL)) begin
        input_pair_select_reg <= pwdata[7:0];
      end
      if (cfg_wr) begin
        converter_config_reg <= {pwdata[7:3], 1'b0, pwdata[1:0]};
      end
      if (wr_commit && addr_hit(paddr, `SAC_OFS_IRQEN)) begin
        irq_enable_reg <= pwdata[0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      converter_on_bit_reg    <= 1'(`SAC_CTRL_RST >> `SAC_CTRL_EN);
      track_mode_select_reg   <= 1'b0;
      start_source_select_reg <= `SAC_SRC_SW;
    end else if (ctrl_wr) begin
      converter_on_bit_reg    <= pwdata[`SAC_CTRL_EN];
      track_mode_select_reg   <= pwdata[`SAC_CTRL_TM];
      start_source_select_reg <= pwdata[2:0];
    end
  end

  // a finishing conversion beats a software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_done_flag_reg <= 1'b0;
    end else if (conv_finish) begin
      conv_done_flag_reg <= 1'b1;
    end else if (ctrl_wr && !pwdata[`SAC_CTRL_DONE]) begin
      conv_done_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_irq <= 1'b0;
    end else begin
      conv_irq <= conv_done_flag_reg & irq_enable_reg;
    end
  end

  // ****************************************
  // synchronisers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strobe_s1_reg <= 1'b0;
      strobe_s2_reg <= 1'b0;
      strobe_s3_reg <= 1'b0;
      cmp_s1_reg    <= 1'b0;
      cmp_s2_reg    <= 1'b0;
    end else begin
      strobe_s1_reg <= ext_start_strobe;
      strobe_s2_reg <= strobe_s1_reg;
      strobe_s3_reg <= strobe_s2_reg;
      cmp_s1_reg    <= sar_cmp;
      cmp_s2_reg    <= cmp_s1_reg;
    end
  end

  // ****************************************
  // start selection
  // ****************************************
  assign t2_ovf      = timers.t2_8bit ? timers.t2_lo_ovf : timers.t2_hi_ovf;
  assign strobe_rise = strobe_s2_reg & ~strobe_s3_reg;

  always_comb begin
    start_evt = 1'b0;
    if (start_source_select_reg[2]) begin
      start_evt = strobe_rise;
    end else begin
      case (start_source_select_reg)
        `SAC_SRC_SW: start_evt = 1'b0;
        `SAC_SRC_T0: start_evt = timers.t0_ovf;
        `SAC_SRC_T2: start_evt = t2_ovf;
        `SAC_SRC_T1: start_evt = timers.t1_ovf;
        default:     start_evt = 1'b0;
      endcase
    end
    // busy write counts only when the written mode is software
    if (ctrl_wr && pwdata[`SAC_CTRL_BUSY] && pwdata[2:0] == `SAC_SRC_SW) begin
      start_evt = 1'b1;
    end
  end

  assign fire = start_evt & converter_on_bit_reg & (state_reg == SAC_IDLE);

  // ****************************************
  // sar clock divider
  // ****************************************
  // clamp keeps throughput at or below the converter maximum
  assign div_eff = (converter_config_reg[7:3] < 5'(`SAC_SAR_MIN_DIV)) ?
                   5'(`SAC_SAR_MIN_DIV) : converter_config_reg[7:3];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_reg  <= 5'h00;
      sar_tick_reg <= 1'b0;
    end else if (fire || !converter_on_bit_reg) begin
      div_cnt_reg  <= 5'h00;
      sar_tick_reg <= 1'b0;
    end else if (div_cnt_reg >= div_eff) begin
      div_cnt_reg  <= 5'h00;
      sar_tick_reg <= 1'b1;
    end else begin
      div_cnt_reg  <= div_cnt_reg + 5'h01;
      sar_tick_reg <= 1'b0;
    end
  end

  // ****************************************
  // conversion sequencer
  // ****************************************
  assign bit_idx     = 3'(4'h8 - step_reg);
  assign conv_finish = (state_reg == SAC_CONV) & sar_tick_reg &
                       (step_reg == 4'(`SAC_CONV_CLKS - 1)) & converter_on_bit_reg;
  assign single_ended = input_pair_select_reg[`SAC_INSEL_NEG_GND];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= SAC_IDLE;
      step_reg  <= 4'h0;
      sar_reg   <= 8'h00;
    end else if (!converter_on_bit_reg) begin
      state_reg <= SAC_IDLE;
      step_reg  <= 4'h0;
    end else begin
      case (state_reg)
        SAC_IDLE: begin
          step_reg <= 4'h0;
          if (fire) begin
            if (track_mode_select_reg && !start_source_select_reg[2]) begin
              state_reg <= SAC_TRACK;
            end else begin
              state_reg <= SAC_CONV;
            end
          end
        end
        SAC_TRACK: begin
          if (sar_tick_reg) begin
            if (step_reg == 4'(`SAC_TRACK_CLKS - 1)) begin
              state_reg <= SAC_CONV;
              step_reg  <= 4'h0;
            end else begin
              step_reg <= step_reg + 4'h1;
            end
          end
        end
        SAC_CONV: begin
          if (sar_tick_reg) begin
            if (step_reg == 4'h0) begin
              sar_reg <= `SAC_SAR_FIRST;
            end else begin
              sar_reg[bit_idx] <= cmp_s2_reg;
              if (bit_idx != 3'h0) begin
                sar_reg[bit_idx - 3'h1] <= 1'b1;
              end
            end
            if (conv_finish) begin
              state_reg <= SAC_IDLE;
            end else begin
              step_reg <= step_reg + 4'h1;
            end
          end
        end
        default: begin
          state_reg <= SAC_IDLE;
          step_reg  <= 4'h0;
        end
      endcase
    end
  end

  // result lands on the same edge that sets the done flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conversion_result_reg <= `SAC_RESULT_RST;
    end else if (conv_finish) begin
      conversion_result_reg <= fmt_code({sar_reg[7:1], cmp_s2_reg}, single_ended);
    end
  end

  // ****************************************
  // analog front-end controls
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_ctrl <= '0;
    end else begin
      analog_ctrl.powered      <= converter_on_bit_reg;
      analog_ctrl.track        <= converter_on_bit_reg & ~low_power_standby &
                                  ((state_reg == SAC_TRACK) |
                                   ((state_reg == SAC_IDLE) & ~track_mode_select_reg) |
                                   ((state_reg == SAC_IDLE) & track_mode_select_reg &
                                    start_source_select_reg[2] & ~strobe_s2_reg));
      analog_ctrl.pos_sel      <= input_pair_select_reg[3:0];
      analog_ctrl.neg_sel      <= input_pair_select_reg[7:`SAC_INSEL_NEG_LSB];
      analog_ctrl.single_ended <= single_ended;
      analog_ctrl.gain         <= sac_gain_t'(converter_config_reg[1:0]);
      analog_ctrl.trial        <= sar_reg;
    end
  end

endmodule : sac_top

// ---- tb/sac_checker.sv ----
// concurrent checks on the converter control ports
// assumes one pclk domain and a bind onto sac_top
`timescale 1ns/1ps
module sac_checker
  import sac_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        low_power_standby,
  input sac_analog_t      analog_ctrl,
  input wire logic        conv_irq
);
  // ****
  // assertions
  // ****
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  apb_one_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("ready missing in second access cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  unmapped_err_a: assert property (pready |-> pslverr == (paddr > 12'h013))
    else $error("error response does not match address");
  rdata_upper_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  off_no_track_a: assert property (!analog_ctrl.powered |-> !analog_ctrl.track)
    else $error("tracking while converter off");
  standby_track_a: assert property (low_power_standby [*3] |-> !analog_ctrl.track)
    else $error("tracking during standby");
  mode_decode_a: assert property (analog_ctrl.single_ended == analog_ctrl.neg_sel[3])
    else $error("single-ended flag not tied to ground select");
  gain_reset_a: assert property ($rose(presetn) |-> ##2 analog_ctrl.gain == SAC_GAIN_HALF)
    else $error("gain not one half after reset");
  irq_powered_a: assert property ($rose(conv_irq) |-> analog_ctrl.powered)
    else $error("completion while converter off");

  cover property ($rose(conv_irq));
  cover property (pready && pslverr);
  cover property ($fell(analog_ctrl.track) && analog_ctrl.powered);
endmodule : sac_checker

bind sac_top sac_checker i_chk (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .low_power_standby(low_power_standby), .analog_ctrl(analog_ctrl), .conv_irq(conv_irq));

// ---- tb/sac_front_model.sv ----
// behavioural analog front end: comparator against a held input code
// assumes trial and power controls from the converter control
`timescale 1ns/1ps
module sac_front_model
  import sac_pkg::*;
(
  input wire logic       pclk,
  input sac_analog_t     analog_ctrl,
  input wire logic [7:0] level,
  output logic           sar_cmp
);
  logic toggle_reg = 1'b0;

  always_ff @(posedge pclk) begin
    toggle_reg <= ~toggle_reg;
  end

  // an unpowered comparator gives no answer, so its output wanders
  assign sar_cmp = analog_ctrl.powered ? (level >= analog_ctrl.trial) : toggle_reg;
endmodule : sac_front_model

// ---- tb/sac_top_tb.sv ----
// self-checking bench of the converter control
// assumes the front model and the checker bind are compiled alongside
`timescale 1ns/1ps
module sac_top_tb
  import sac_pkg::*;
;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        strobe = 1'b0;
  logic        stby = 1'b0;
  logic        tm = 1'b0;
  logic        cmp, pready, pslverr, irq, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic [7:0]  level = 8'hA5;
  sac_timer_t  tmr = '0;
  sac_analog_t actl;
  int          bad_count = 0;
  int          n_compared = 0;
  int          n;
  logic [28:0] rows [6] = '{{12'h000, 8'h8A, 8'h8A, 1'h0}, {12'h004, 8'hFF, 8'hFB, 1'h0},
    {12'h008, 8'h55, 8'h00, 1'h0}, {12'h010, 8'h01, 8'h01, 1'h0},
    {12'h00C, 8'h0F, 8'h07, 1'h0}, {12'h014, 8'h12, 8'h00, 1'h1}};
  logic [7:0]  rst_tab [5] = '{8'h00, 8'hF8, 8'h00, 8'h00, 8'h00};
  logic [2:0]  mode_tab [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h2};
  int          src_tab [6] = '{0, 1, 3, 4, 5, 2};

  always #20 pclk = ~pclk;

  sac_top i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timers(tmr), .ext_start_strobe(strobe), .low_power_standby(stby), .sar_cmp(cmp),
    .analog_ctrl(actl), .conv_irq(irq));
  sac_front_model i_fe (.pclk(pclk), .analog_ctrl(actl), .level(level), .sar_cmp(cmp));

  // ****
  // tasks
  // ****
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      bad_count++;
      $display("Error at %0t ns: seen %h expected %h", $time, s, e);
    end
  endtask : chk

  // entered right after a rising edge, leaves one edge after completion
  task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic fire(input int k, input logic [2:0] m);
    if (k == 0) begin
      apb(12'h00C, 1'b1, {1'b1, tm, 3'h2, m});
    end else if (k == 5) begin
      strobe <= 1'b0;
      repeat (4) @(posedge pclk);
      strobe <= 1'b1;
      @(posedge pclk);
    end else begin
      tmr[k == 1 ? 4 : k == 4 ? 3 : 4 - k] <= 1'b1;
      @(posedge pclk);
      tmr[k == 1 ? 4 : k == 4 ? 3 : 4 - k] <= 1'b0;
    end
  endtask : fire

  task automatic conv(input logic [7:0] e, input logic [2:0] m);
    for (int i = 0; i < 100; i++) begin
      apb(12'h00C, 1'b0, 8'h00);
      if (q[5] === 1'b1) break;
    end
    apb(12'h00C, 1'b0, 8'h00);
    chk(q[7:4], {1'b1, tm, 2'h2});
    chk(irq, 1'b1);
    apb(12'h008, 1'b0, 8'h00);
    chk(q, e);
    apb(12'h00C, 1'b1, {1'b1, tm, 3'h0, m});
    apb(12'h00C, 1'b0, 8'h00);
    chk(q[5], 1'b0);
    chk(irq, 1'b0);
  endtask : conv

  task automatic end_sim;
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim

  initial begin
    repeat (40000) @(posedge pclk);
    bad_count++;
    end_sim;
  end

  // ****
  // tests
  // ****
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (rows[i]) begin
      apb(rows[i][28:17], 1'b1, rows[i][16:9]);
      chk(err, rows[i][0]);
      apb(rows[i][28:17], 1'b0, 8'h00);
      chk(q, rows[i][8:1]);
    end
    presetn <= 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 5; i++) begin
      apb(12'(4 * i), 1'b0, 8'h00);
      chk(q, rst_tab[i]);
    end
    apb(12'h010, 1'b1, 8'h01);
    apb(12'h00C, 1'b1, 8'h80);
    for (int g = 0; g < 4; g++) begin
      apb(12'h004, 1'b1, {6'h00, 2'(g)});
      @(posedge pclk);
      chk(actl.gain, g);
    end
    apb(12'h000, 1'b1, 8'h83);
    @(posedge pclk);
    chk({actl.pos_sel, actl.neg_sel, actl.single_ended}, 9'h071);
    chk(actl.track, 1'b1);
    stby <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(actl.track, 1'b0);
    stby <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      tmr.t2_8bit <= (i == 5);
      apb(12'h00C, 1'b1, {5'h10, mode_tab[i]});
      for (int k = 0; k < 6; k++) begin
        fire(k, mode_tab[i]);
        repeat (4) @(posedge pclk);
        apb(12'h00C, 1'b0, 8'h00);
        chk(q[4], k == src_tab[i]);
        if (k == src_tab[i]) conv(level, mode_tab[i]);
      end
    end
    apb(12'h000, 1'b1, 8'h03);
    fire(0, 3'h0);
    @(posedge pclk);
    chk({actl.track, actl.single_ended}, 2'h0);
    conv(level ^ 8'h80, 3'h0);
    tm = 1'b1;
    apb(12'h000, 1'b1, 8'h83);
    apb(12'h00C, 1'b1, 8'hC0);
    repeat (3) @(posedge pclk);
    chk(actl.track, 1'b0);
    fire(0, 3'h0);
    @(posedge pclk);
    chk(actl.track, 1'b1);
    conv(level, 3'h0);
    apb(12'h00C, 1'b1, 8'hC4);
    strobe <= 1'b0;
    repeat (6) @(posedge pclk);
    chk(actl.track, 1'b1);
    strobe <= 1'b1;
    repeat (6) @(posedge pclk);
    chk(actl.track, 1'b0);
    conv(level, 3'h4);
    tm = 1'b0;
    apb(12'h00C, 1'b1, 8'h80);
    // divider 7: eight pclk per sar clock; a second start mid-conversion must not restart it
    apb(12'h004, 1'b1, 8'h38);
    fire(0, 3'h0);
    apb(12'h00C, 1'b1, 8'h90);
    for (n = 5; irq !== 1'b1 && n < 400; n++) @(posedge pclk);
    chk(n > 9 * 8 && n <= 9 * 8 + 4, 1'b1);
    fire(0, 3'h0);
    apb(12'h00C, 1'b1, 8'h00);
    apb(12'h00C, 1'b1, 8'h10);
    apb(12'h00C, 1'b0, 8'h00);
    chk(q, 32'h0);
    chk(actl.powered, 1'b0);
    end_sim;
  end
endmodule : sac_top_tb
